// ==== hw/pwm_pkg.sv ====
// Purpose: constants shared by the dual pulse-division pwm block
// Assumes: registers are one 8-bit value per 32-bit wishbone word
// Notes: byte address of a register is four times its index
//
// Overview of operation
// - two identical 10-bit pwm channels, each with its own output pin
// - clock select 00/01/10/11 gives system clock divided by 1/2/4/8, reset 00
// - one conversion period lasts 512 input clocks
// - high time resolves in half input-clock steps, except at select 00 where it resolves in whole clocks
// - clock-control register is write-only, select bits read as ones
// - clock-control bits 7..2 read as one and ignore writes
// - clock-control register resets to FC
// - duty is upper byte bits 1..0 over the lower byte
// - duty sets total high time within one conversion period
// - written duty moves whole into the generator, which then continues
// - reads of either duty byte return all ones
// - upper duty resets to FC, lower duty resets to 00
// - standby bit 4 serves channel b, bit 1 serves channel a
// - stop bit 0 puts channel in standby, 1 releases, resets to 1
// - clock-stop register resets to FF, standby bits read and write
// - upper byte write latches duty, taken up at the period boundary
// - period holds four pulses whose high widths sum to (duty+4) half steps, at most 1024

package pwm_pkg;

	// ***************************************************
	// register indices
	// ***************************************************
	localparam logic [15:0] IDX_B_CLOCK_CONTROL = 16'hFFCD;
	localparam logic [15:0] IDX_B_DUTY_UPPER = 16'hFFCE;
	localparam logic [15:0] IDX_B_DUTY_LOWER = 16'hFFCF;
	localparam logic [15:0] IDX_A_CLOCK_CONTROL = 16'hFFD0;
	localparam logic [15:0] IDX_A_DUTY_UPPER = 16'hFFD1;
	localparam logic [15:0] IDX_A_DUTY_LOWER = 16'hFFD2;
	localparam logic [15:0] IDX_MODULE_CLOCK_STOP_B = 16'hFFFB;

	// ***************************************************
	// reset values and fields
	// ***************************************************
	localparam logic [7:0] RST_CLOCK_CONTROL = 8'hFC;
	localparam logic [7:0] RST_DUTY_UPPER = 8'hFC;
	localparam logic [7:0] RST_DUTY_LOWER = 8'h00;
	localparam logic [7:0] RST_MODULE_CLOCK_STOP_B = 8'hFF;
	localparam logic [7:0] READ_ALL_ONES = 8'hFF;
	localparam int CHAN_A_STOP_BIT = 1;
	localparam int CHAN_B_STOP_BIT = 4;
	localparam logic [7:0] STOP_WRITABLE_MASK = 8'h12;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int HALF_STEPS_PER_PERIOD = 1024;
	localparam int HALF_STEPS_PER_PULSE = 256;
	localparam logic [10:0] DUTY_OFFSET = 11'h004;

endpackage

// ==== hw/dual_pwm.sv ====
// Purpose: two pulse-division pwm channels behind a classic wishbone slave
// Assumes: single 125 MHz clock, 8-bit registers in the low byte of each word
// Notes: with the undivided clock the half step cannot be made, see below
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps

module dual_pwm
	import pwm_pkg::*;
(
	// clock, reset, freeze
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	// wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [17:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// pwm pins
	output logic PULSE_OUT_A_O,
	output logic PULSE_OUT_B_O
);
	import pwm_pkg::*;

	// ***************************************************
	// helpers
	// ***************************************************

	// prescale limit in system clocks per counter step, minus one
	function automatic logic [1:0] pre_limit(input logic [1:0] sel);
		unique case (sel)
			2'b00: pre_limit = 2'd0;
			2'b01: pre_limit = 2'd0;
			2'b10: pre_limit = 2'd1;
			2'b11: pre_limit = 2'd3;
		endcase
	endfunction

	// high width of one pulse in half steps
	function automatic logic [8:0] pulse_width(input logic [9:0] duty, input logic [1:0] slot);
		logic [10:0] sum;
		logic [8:0] extra;
		sum = {1'b0, duty} + DUTY_OFFSET;
		extra = (slot < sum[1:0]) ? 9'd1 : 9'd0;
		pulse_width = sum[10:2] + extra;
	endfunction

	// ***************************************************
	// bus decode
	// ***************************************************
	logic req;
	logic wr_en;
	logic [15:0] idx;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] rd_byte;

	assign req = CYC_I & STB_I & ~ack_q;
	// write lands at the edge where the master samples ack high
	assign wr_en = CYC_I & STB_I & ack_q & WE_I & SEL_I[0];
	assign idx = ADR_I[17:2];

	// ***************************************************
	// registers
	// ***************************************************
	logic [1:0] clk_sel_q [2];
	logic [1:0] duty_upper_q [2];
	logic [7:0] duty_lower_q [2];
	logic [9:0] duty_pend_q [2];
	logic pend_q [2];
	logic [7:0] module_clock_stop_b_q;
	logic run [2];
	logic [15:0] idx_cc [2];
	logic [15:0] idx_du [2];
	logic [15:0] idx_dl [2];

	assign idx_cc[0] = IDX_A_CLOCK_CONTROL;
	assign idx_cc[1] = IDX_B_CLOCK_CONTROL;
	assign idx_du[0] = IDX_A_DUTY_UPPER;
	assign idx_du[1] = IDX_B_DUTY_UPPER;
	assign idx_dl[0] = IDX_A_DUTY_LOWER;
	assign idx_dl[1] = IDX_B_DUTY_LOWER;
	assign run[0] = module_clock_stop_b_q[CHAN_A_STOP_BIT];
	assign run[1] = module_clock_stop_b_q[CHAN_B_STOP_BIT];

	// clock select; reserved bits are not stored at all
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int c = 0; c < 2; c++) begin
				clk_sel_q[c] <= RST_CLOCK_CONTROL[1:0];
			end
		end else if (CE_I) begin
			for (int c = 0; c < 2; c++) begin
				if (wr_en && idx == idx_cc[c]) begin
					clk_sel_q[c] <= DAT_I[1:0];
				end
			end
		end
	end

	// duty bytes; upper write builds the pending 10-bit word
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int c = 0; c < 2; c++) begin
				duty_upper_q[c] <= RST_DUTY_UPPER[1:0];
				duty_lower_q[c] <= RST_DUTY_LOWER;
				duty_pend_q[c] <= {RST_DUTY_UPPER[1:0], RST_DUTY_LOWER};
			end
		end else if (CE_I) begin
			for (int c = 0; c < 2; c++) begin
				if (wr_en && idx == idx_dl[c]) begin
					duty_lower_q[c] <= DAT_I[7:0];
				end
				if (wr_en && idx == idx_du[c]) begin
					duty_upper_q[c] <= DAT_I[1:0];
					// lower byte must already be in place
					duty_pend_q[c] <= {DAT_I[1:0], duty_lower_q[c]};
				end
			end
		end
	end

	// shared stop register; only the two pwm bits move
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			module_clock_stop_b_q <= RST_MODULE_CLOCK_STOP_B;
		end else if (CE_I) begin
			if (wr_en && idx == IDX_MODULE_CLOCK_STOP_B) begin
				module_clock_stop_b_q <= (DAT_I[7:0] & STOP_WRITABLE_MASK) | ~STOP_WRITABLE_MASK;
			end
		end
	end

	// ***************************************************
	// wishbone answer
	// ***************************************************
	always_comb begin
		rd_byte = 8'h00;
		if (idx == IDX_MODULE_CLOCK_STOP_B) begin
			rd_byte = module_clock_stop_b_q;
		end
		for (int c = 0; c < 2; c++) begin
			if (idx == idx_cc[c]) begin
				rd_byte = READ_ALL_ONES;
			end
			if (idx == idx_du[c] || idx == idx_dl[c]) begin
				rd_byte = READ_ALL_ONES;
			end
		end
	end

	// one wait-free answer, ack drops the cycle after
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else if (CE_I) begin
			ack_q <= req;
			if (req && !WE_I) begin
				dat_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign ACK_O = ack_q;
	assign DAT_O = dat_q;

	// ***************************************************
	// waveform generators
	// ***************************************************
	logic [1:0] pre_q [2];
	logic [9:0] half_q [2];
	logic [9:0] duty_act_q [2];
	logic out_q [2];
	logic step [2];
	logic [9:0] half_d [2];
	logic wrap [2];

	// the undivided clock cannot place a half cycle, so it steps two half
	// steps per clock and odd widths round up to whole system clocks
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			step[c] = run[c] && pre_q[c] == pre_limit(clk_sel_q[c]);
			if (clk_sel_q[c] == 2'b00) begin
				half_d[c] = half_q[c] + 10'd2;
			end else begin
				half_d[c] = half_q[c] + 10'd1;
			end
			// 1024 half steps make 512 input clocks
			wrap[c] = step[c] && half_d[c] < half_q[c];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int c = 0; c < 2; c++) begin
				pre_q[c] <= 2'd0;
				half_q[c] <= 10'd0;
			end
		end else if (CE_I) begin
			for (int c = 0; c < 2; c++) begin
				if (run[c]) begin
					if (step[c]) begin
						pre_q[c] <= 2'd0;
						half_q[c] <= half_d[c];
					end else begin
						pre_q[c] <= pre_q[c] + 2'd1;
					end
				end
			end
		end
	end

	// pending duty taken up only at a period boundary, so a period is never torn
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int c = 0; c < 2; c++) begin
				duty_act_q[c] <= {RST_DUTY_UPPER[1:0], RST_DUTY_LOWER};
				pend_q[c] <= 1'b0;
			end
		end else if (CE_I) begin
			for (int c = 0; c < 2; c++) begin
				if (wr_en && idx == idx_du[c]) begin
					pend_q[c] <= 1'b1;
				end else if (wrap[c] && pend_q[c]) begin
					pend_q[c] <= 1'b0;
				end
				if (wrap[c] && pend_q[c]) begin
					duty_act_q[c] <= duty_pend_q[c];
				end
			end
		end
	end

	// four sub-periods, each high from its start for its share of the width
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int c = 0; c < 2; c++) begin
				out_q[c] <= 1'b0;
			end
		end else if (CE_I) begin
			for (int c = 0; c < 2; c++) begin
				if (!run[c]) begin
					out_q[c] <= 1'b0;
				end else begin
					out_q[c] <= {1'b0, half_q[c][7:0]} <
						pulse_width(duty_act_q[c], half_q[c][9:8]);
				end
			end
		end
	end

	assign PULSE_OUT_A_O = out_q[0];
	assign PULSE_OUT_B_O = out_q[1];

endmodule

// ==== test/lp_filter.sv ====
// Purpose: low-pass load on a pwm pin, kept as a high-time integrator
// Assumes: one pin sample per system clock
// Notes: clr_i empties it, so one window gives the filtered level
`timescale 1ns/100ps
module lp_filter (
	input wire logic clk_i, clr_i, pin_i,
	output int acc_o
);
	always_ff @(posedge clk_i)
		acc_o <= clr_i ? 0 : acc_o + int'(pin_i);
endmodule

// ==== test/dual_pwm_asserts.sv ====
// Purpose: bus and pin checks for dual_pwm
// Assumes: ack comes one cycle after a request
// Notes: stop byte mirrored from bus writes
`timescale 1ns/100ps
module dual_pwm_asserts
	import pwm_pkg::*;
(
	input wire logic CLK_I, RST_B_I, CE_I, CYC_I, STB_I, WE_I, ACK_O,
	input wire logic PULSE_OUT_A_O, PULSE_OUT_B_O,
	input wire logic [3:0] SEL_I,
	input wire logic [17:0] ADR_I,
	input wire logic [31:0] DAT_I, DAT_O
);
	// 255 low half steps of 4 clocks, slack for prescaler phase
	localparam int LO_MAX = 1030;
	logic [7:0] stop_q;
	logic [10:0] lo_q;
	wire logic [15:0] idx = ADR_I[17:2];
	wire logic take = CYC_I && STB_I && !ACK_O && CE_I;
	wire logic rd_ack = ACK_O && !WE_I;
	wire logic is_ctl = idx inside {IDX_A_CLOCK_CONTROL, IDX_B_CLOCK_CONTROL};
	wire logic is_duty = idx inside {[IDX_B_DUTY_UPPER:IDX_B_DUTY_LOWER], [IDX_A_DUTY_UPPER:IDX_A_DUTY_LOWER]};
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	always_ff @(posedge CLK_I or negedge RST_B_I)
		if (!RST_B_I) stop_q <= 8'hFF;
		else if (CYC_I && STB_I && ACK_O && CE_I && WE_I && SEL_I[0] && idx == IDX_MODULE_CLOCK_STOP_B)
			stop_q <= DAT_I[7:0];
	// run length of low output on channel a while it is running
	always_ff @(posedge CLK_I or negedge RST_B_I)
		if (!RST_B_I) lo_q <= '0;
		else if (PULSE_OUT_A_O || !stop_q[1]) lo_q <= '0;
		else if (CE_I) lo_q <= lo_q + 11'h001;
	sequence s_off_a; (!stop_q[1] && CE_I) [*2]; endsequence
	sequence s_off_b; (!stop_q[4] && CE_I) [*2]; endsequence
	a_ack_next: assert property (take |=> ACK_O)
		else $error("request not acked");
	a_ack_pulse: assert property (ACK_O && CE_I |=> !ACK_O)
		else $error("ack too long");
	a_ctl_ones: assert property (rd_ack && is_ctl |-> DAT_O[7:0] == 8'hFF)
		else $error("control read not ones");
	a_duty_ones: assert property (rd_ack && is_duty |-> DAT_O[7:0] == 8'hFF)
		else $error("duty read not ones");
	a_stop_read: assert property (rd_ack && idx == IDX_MODULE_CLOCK_STOP_B |-> DAT_O[7:0] == (stop_q | 8'hED))
		else $error("stop read wrong");
	a_stop_a_low: assert property (s_off_a |=> !PULSE_OUT_A_O)
		else $error("stopped a not low");
	a_stop_b_low: assert property (s_off_b |=> !PULSE_OUT_B_O)
		else $error("stopped b not low");
	a_sub_gap: assert property (lo_q < LO_MAX)
		else $error("sub-period without high");
endmodule
bind dual_pwm dual_pwm_asserts u_chk (.*);

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for dual_pwm
// Assumes: 8 ns clock, bench is the bus master
// Notes: high time counted over one whole period
`timescale 1ns/100ps
module tb_top;
	import pwm_pkg::*;
	logic CLK_I, RST_B_I, CE_I, CYC_I, STB_I, WE_I, ACK_O, PULSE_OUT_A_O, PULSE_OUT_B_O, clr;
	logic [17:0] ADR_I;
	logic [3:0] SEL_I;
	logic [31:0] DAT_I, DAT_O;
	int acc_a, acc_b, err_total, samples_checked, cyc_n, da, db;
	dual_pwm u_dut (.*);
	lp_filter u_fa (.clk_i(CLK_I), .clr_i(clr), .pin_i(PULSE_OUT_A_O), .acc_o(acc_a));
	lp_filter u_fb (.clk_i(CLK_I), .clr_i(clr), .pin_i(PULSE_OUT_B_O), .acc_o(acc_b));
	// odd half steps round up to a clock at the fastest select
	function automatic int hi_clk(int d, int s);
		int w, t;
		t = 0;
		for (int k = 0; k < 4; k++) begin
			w = (d + 7 - k) / 4 > 256 ? 256 : (d + 7 - k) / 4;
			t += (w * (1 << s) + 1) / 2;
		end
		return t;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] wd, input logic [7:0] e);
		int n;
		n = 0;
		{CYC_I, STB_I, WE_I} <= {2'b11, w};
		ADR_I <= {a, 2'b00};
		DAT_I <= {24'h0, wd};
		do @(posedge CLK_I); while (ACK_O !== 1'b1 && ++n < 20);
		chk(32'(n < 20), 32'h1);
		if (!w) chk(DAT_O, {24'h0, e});
		{CYC_I, STB_I} <= 2'b00;
		@(posedge CLK_I);
	endtask
	task automatic set(input logic [15:0] b, input int s, input int d);
		bus(1'b1, b, 8'($urandom) & 8'hFC | 8'(s), 8'h0);
		bus(1'b1, b + 16'h2, d[7:0], 8'h0);
		bus(1'b1, b + 16'h1, {6'($urandom), d[9:8]}, 8'h0);
	endtask
	// wait two periods so a pending duty is surely in use
	task automatic measure(input int s, input int ea, input int eb);
		repeat (1024 << s) @(posedge CLK_I);
		clr <= 1'b1;
		@(posedge CLK_I);
		clr <= 1'b0;
		repeat ((512 << s) + 1) @(posedge CLK_I);
		chk(acc_a, ea);
		chk(acc_b, eb);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		CLK_I = 1'b0;
		forever #4 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I)
		if (++cyc_n == 50000) begin
			err_total++;
			wrap_up();
		end
	initial begin
		{RST_B_I, CE_I, CYC_I, STB_I, WE_I, clr} = 6'h10;
		ADR_I = '0;
		SEL_I = 4'hF;
		DAT_I = '0;
		void'($urandom(37846));
		repeat (3) @(posedge CLK_I);
		RST_B_I <= 1'b1;
		@(posedge CLK_I);
		for (int i = 0; i < 6; i++)
			bus(1'b0, 16'(IDX_B_CLOCK_CONTROL + i), 8'h0, 8'hFF);
		bus(1'b0, IDX_MODULE_CLOCK_STOP_B, 8'h0, 8'hFF);
		bus(1'b0, 16'h0000, 8'h0, 8'h00);
		measure(0, hi_clk(0, 0), hi_clk(0, 0));
		for (int s = 0; s < 4; s++) begin
			da = s == 3 ? 1023 : int'($urandom_range(1019, 0));
			db = s == 0 ? 1 : int'($urandom_range(1023, 0));
			set(IDX_A_CLOCK_CONTROL, s, da);
			set(IDX_B_CLOCK_CONTROL, s, db);
			bus(1'b0, IDX_A_CLOCK_CONTROL, 8'h0, 8'hFF);
			measure(s, hi_clk(da, s), hi_clk(db, s));
		end
		bus(1'b1, IDX_MODULE_CLOCK_STOP_B, 8'($urandom) & 8'hED, 8'h0);
		bus(1'b0, IDX_MODULE_CLOCK_STOP_B, 8'h0, 8'hED);
		measure(3, 0, 0);
		wrap_up();
	end
endmodule
